// File: hdl/trl_defines.svh
// Constants of the configuration readout and error log block.
`ifndef TRL_DEFINES_SVH
`define TRL_DEFINES_SVH
`define SEL_ADDR 7'h1C
`define SEL_LSB 4
`define MASK_HI_ADDR 7'h1C
`define MASK_LO_ADDR 7'h1B
`define CTRL_ADDR 7'h1D
`define RUN_BIT 0
`define TGT_BIT 1
`define FAST_BIT 2
`define LOG0 7'h30
`define LOG1 7'h31
`define LOG2 7'h32
`define LOG3 7'h33
`define LOG_W 10
`define MEM_FIRST 7'h00
`define MEM_LAST 7'h7F
`define SHORT_LAST 7'h31
`define OEM_EE_FIRST 7'h24
`define OEM_RAM_FIRST 7'h3B
`define OEM_RAM_LAST 7'h43
`define SEL_EE_OEM 3'h1
`define SEL_EE_ALL 3'h3
`define SEL_RAM_OEM 3'h5
`define SEL_RAM_ALL 3'h7
`define NO_RELOAD 2'h0
`define TGT_DEV 7'h55
`define CLK_PS 4000
`define FAST_PS 780000
`define SLOW_PS 3125000
`define HALF_FAST (`FAST_PS / `CLK_PS)
`define HALF_SLOW (`SLOW_PS / `CLK_PS)
`define FRAME_HALVES 5'h12
`define PAUSE_HALVES 5'h02
`define EE_TIMEOUT_MS 150
`define EE_TIMEOUT_CYC (`EE_TIMEOUT_MS * 1000000 / (`CLK_PS / 1000))
`endif

// File: hdl/trl_pkg.sv
// Types of the configuration readout and error log block.
`default_nettype none
package trl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_FETCH, ST_SEND} state_t;
endpackage
`default_nettype wire

// File: hdl/trl_readout.sv
// Configuration reload, test readout over the alarm pin, target writes and error log.
`timescale 1ns/100ps
`default_nettype none
`include "trl_defines.svh"
module trl_readout #(
  parameter int EE_TIMEOUT = `EE_TIMEOUT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic TEST_ENTRY,
  input wire logic TEST_EXIT,
  input wire logic FULL_RELOAD,
  input wire logic [9:0] ERR_EVENT,
  output logic EE_REQ,
  output logic [6:0] EE_ADDR,
  input wire logic EE_ACK,
  input wire logic EE_NACK,
  input wire logic [7:0] EE_DATA,
  input wire logic TGT_WR,
  input wire logic [6:0] TGT_DEV,
  input wire logic [6:0] TGT_ADDR,
  input wire logic [7:0] TGT_DATA,
  output logic ERR_SINK_O,
  output logic ERR_SINK_OE,
  output logic TEST_MODE,
  output logic RUN_ENABLE,
  output logic TARGET_ENABLE,
  output logic LOG_STORE
);

  localparam int TW = $clog2(EE_TIMEOUT + 1);

  if (EE_TIMEOUT < 2 || `HALF_SLOW > 1024) begin : g_bad
    $error("trl_readout: timeout or readout period out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [127:0][7:0] mem;
    trl_pkg::state_t state;
    logic tm;
    logic pend;
    logic ram;
    logic sink;
    logic store;
    logic [2:0] sy_en;
    logic [2:0] sy_ex;
    logic en_lvl;
    logic ex_lvl;
    logic [6:0] addr;
    logic [6:0] last;
    logic [TW-1:0] tmr;
    logic [8:0] sh;
    logic [4:0] hidx;
    logic [9:0] hcnt;
  } st_t;

  st_t s;
  st_t next_s;

  function automatic logic [9:0] half_len(input logic fast);
    half_len = fast ? 10'(`HALF_FAST - 1) : 10'(`HALF_SLOW - 1);
  endfunction

  logic [2:0] sel;
  logic [9:0] mask;
  logic [9:0] ev;
  logic fast;
  logic tgt_en;
  logic en_go;
  logic tgt_hit;
  logic timeout;
  logic [7:0] rd;
  logic [31:0] logw;
  logic tx;
  logic [6:0] t_first;
  logic [6:0] t_last;
  logic ee_fail;
  logic [31:0] lw;

  assign sel = s.mem[`SEL_ADDR][`SEL_LSB +: 3];
  assign mask = {s.mem[`MASK_HI_ADDR][1:0], s.mem[`MASK_LO_ADDR]};
  assign ev = ERR_EVENT & mask;
  assign fast = s.mem[`CTRL_ADDR][`FAST_BIT];
  assign tgt_en = s.mem[`CTRL_ADDR][`TGT_BIT];
  // A rising entry level counts once the last two sync stages agree.
  assign en_go = (s.sy_en[2] == s.sy_en[1]) && s.sy_en[2] && !s.en_lvl;
  assign tgt_hit = TGT_WR && (TGT_DEV == `TGT_DEV) && tgt_en;
  assign timeout = s.tmr == TW'(EE_TIMEOUT - 1);
  assign rd = s.mem[s.addr];
  assign logw = {s.mem[`LOG3], s.mem[`LOG2], s.mem[`LOG1], s.mem[`LOG0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_s = s;
    tx = 1'b0;
    t_first = `MEM_FIRST;
    t_last = `MEM_LAST;
    ee_fail = 1'b0;
    lw = '0;
    next_s.store = 1'b0;
    next_s.sy_en = {s.sy_en[1:0], TEST_ENTRY};
    next_s.sy_ex = {s.sy_ex[1:0], TEST_EXIT};
    if (s.sy_en[2] == s.sy_en[1]) begin
      next_s.en_lvl = s.sy_en[2];
    end
    if (s.sy_ex[2] == s.sy_ex[1]) begin
      next_s.ex_lvl = s.sy_ex[2];
    end
    unique case (s.state)
      trl_pkg::ST_IDLE: begin
        if (s.pend && !s.tm) begin
          next_s.pend = 1'b0;
          next_s.state = trl_pkg::ST_LOAD;
          next_s.addr = `MEM_FIRST;
          next_s.last = FULL_RELOAD ? `MEM_LAST : `SHORT_LAST;
          next_s.tmr = '0;
        end
      end
      trl_pkg::ST_LOAD: begin
        if (EE_ACK) begin
          next_s.mem[s.addr] = EE_DATA;
          next_s.tmr = '0;
          if (s.addr == s.last) begin
            next_s.state = trl_pkg::ST_IDLE;
          end else begin
            next_s.addr = s.addr + 7'h01;
          end
        end else begin
          next_s.tmr = s.tmr + 1'b1;
          ee_fail = EE_NACK || timeout;
        end
      end
      trl_pkg::ST_FETCH: begin
        if (s.ram) begin
          next_s.sh = {1'b1, rd};
          next_s.state = trl_pkg::ST_SEND;
          next_s.hidx = '0;
          next_s.hcnt = half_len(fast);
        end else if (EE_ACK) begin
          // The fresh EEPROM byte also refreshes the RAM copy.
          next_s.mem[s.addr] = EE_DATA;
          next_s.sh = {1'b1, EE_DATA};
          next_s.state = trl_pkg::ST_SEND;
          next_s.hidx = '0;
          next_s.hcnt = half_len(fast);
        end else begin
          next_s.tmr = s.tmr + 1'b1;
          ee_fail = EE_NACK || timeout;
        end
      end
      trl_pkg::ST_SEND: begin
        if (s.hcnt != 10'h000) begin
          next_s.hcnt = s.hcnt - 10'h001;
        end else begin
          next_s.hcnt = half_len(fast);
          next_s.hidx = s.hidx + 5'h01;
          if (s.hidx[0]) begin
            next_s.sh = {s.sh[7:0], 1'b0};
          end
          if (s.hidx == `FRAME_HALVES + `PAUSE_HALVES - 5'h01) begin
            if (s.addr == s.last) begin
              next_s.state = trl_pkg::ST_IDLE;
            end else begin
              next_s.addr = s.addr + 7'h01;
              next_s.state = trl_pkg::ST_FETCH;
              next_s.tmr = '0;
            end
          end
        end
      end
    endcase
    if (ee_fail) begin
      // A silent EEPROM hands the RAM to the target port and halts conversion.
      next_s.state = trl_pkg::ST_IDLE;
      next_s.mem[`CTRL_ADDR][`TGT_BIT] = 1'b1;
      next_s.mem[`CTRL_ADDR][`RUN_BIT] = 1'b0;
    end
    case (sel)
      `SEL_EE_OEM: begin
        tx = 1'b1;
        t_first = `OEM_EE_FIRST;
      end
      `SEL_EE_ALL: begin
        tx = 1'b1;
      end
      `SEL_RAM_OEM: begin
        tx = tgt_en;
        t_first = `OEM_RAM_FIRST;
        t_last = `OEM_RAM_LAST;
      end
      `SEL_RAM_ALL: begin
        tx = tgt_en;
      end
      default: begin
        tx = 1'b0;
      end
    endcase
    if (s.tm && s.ex_lvl) begin
      next_s.tm = 1'b0;
      next_s.state = trl_pkg::ST_IDLE;
      next_s.pend = s.pend || (sel[1:0] != `NO_RELOAD);
    end else if (!s.tm && en_go && sel[0]) begin
      next_s.tm = 1'b1;
      next_s.pend = s.pend || (s.state == trl_pkg::ST_LOAD);
      next_s.state = trl_pkg::ST_IDLE;
      if (tx) begin
        next_s.state = trl_pkg::ST_FETCH;
        next_s.addr = t_first;
        next_s.last = t_last;
        next_s.ram = sel[2];
        next_s.tmr = '0;
      end
    end
    if (tgt_hit) begin
      next_s.mem[TGT_ADDR] = TGT_DATA;
    end
    if (ev != 10'h000) begin
      lw = {next_s.mem[`LOG3], next_s.mem[`LOG2], next_s.mem[`LOG1], next_s.mem[`LOG0]};
      if (lw[0 +: `LOG_W] == 10'h000) begin
        lw[0 +: `LOG_W] = ev;
      end
      lw[`LOG_W +: `LOG_W] = ev;
      lw[2 * `LOG_W +: `LOG_W] = lw[2 * `LOG_W +: `LOG_W] | ev;
      {next_s.mem[`LOG3], next_s.mem[`LOG2], next_s.mem[`LOG1], next_s.mem[`LOG0]} = lw;
      next_s.store = 1'b1;
    end
    // Manchester level: the bit value in the first half, its inverse in the second.
    next_s.sink = (next_s.state == trl_pkg::ST_SEND) && (next_s.hidx < `FRAME_HALVES)
                  && (next_s.sh[8] ^ next_s.hidx[0]);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
      s.pend <= 1'b1;
    end else if (CE) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign EE_REQ = (s.state == trl_pkg::ST_LOAD) || (s.state == trl_pkg::ST_FETCH && !s.ram);
  assign EE_ADDR = s.addr;
  assign ERR_SINK_O = 1'b0;
  assign ERR_SINK_OE = s.sink;
  assign TEST_MODE = s.tm;
  assign RUN_ENABLE = s.mem[`CTRL_ADDR][`RUN_BIT];
  assign TARGET_ENABLE = tgt_en;
  assign LOG_STORE = s.store;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  entry_gate_a: assert property ($rose(s.tm) |-> $past(sel[0]) && $past(en_go))
    else $error("test mode entered without select bit 0");

  exit_abort_a: assert property (CE && s.tm && s.ex_lvl |=> !s.tm && !s.sink && s.state == trl_pkg::ST_IDLE)
    else $error("exit level did not abort test mode");

  reload_exit_a: assert property (CE && s.tm && s.ex_lvl && sel[1:0] != `NO_RELOAD |=> s.pend)
    else $error("reload not scheduled after test mode");

  load_abort_a: assert property (CE && !s.tm && en_go && sel[0] && s.state == trl_pkg::ST_LOAD
    |=> s.pend && s.state != trl_pkg::ST_LOAD)
    else $error("reload not aborted by test mode");

  half_period_a: assert property ($changed(s.sink) && s.state == trl_pkg::ST_SEND && s.hidx != 5'h00
    |-> $past(s.hcnt) == 10'h000 && $past(s.state) == trl_pkg::ST_SEND)
    else $error("sink changed inside a readout period");

  start_bit_a: assert property (s.state == trl_pkg::ST_SEND && s.hidx == 5'h00 |-> s.sink)
    else $error("start bit half not sinking");

  pause_z_a: assert property (s.state == trl_pkg::ST_SEND && s.hidx >= `FRAME_HALVES |-> !s.sink)
    else $error("sink active in frame pause");

  bit_pair_a: assert property (CE && s.state == trl_pkg::ST_SEND && s.hcnt == 10'h000 && !s.hidx[0]
    && s.hidx < `FRAME_HALVES && !(s.tm && s.ex_lvl) |=> s.sink != $past(s.sink))
    else $error("Manchester bit without mid-bit transition");

  ram_src_a: assert property (CE && s.state == trl_pkg::ST_FETCH && s.ram && !(s.tm && s.ex_lvl)
    |=> s.state == trl_pkg::ST_SEND && s.sh == {1'b1, $past(rd)})
    else $error("RAM byte not loaded for readout");

  no_eeprom_a: assert property (CE && s.state == trl_pkg::ST_LOAD && EE_NACK && !EE_ACK && !TGT_WR
    |=> TARGET_ENABLE && !RUN_ENABLE)
    else $error("missing EEPROM not handled");

  target_wr_a: assert property (CE && tgt_hit && ev == 10'h000 && s.state != trl_pkg::ST_LOAD
    && s.state != trl_pkg::ST_FETCH |=> s.mem[$past(TGT_ADDR)] == $past(TGT_DATA))
    else $error("target byte not stored");

  log_words_a: assert property (CE && ev != 10'h000 && !TGT_WR
    |=> LOG_STORE && logw[`LOG_W +: `LOG_W] == $past(ev)
    && (logw[2 * `LOG_W +: `LOG_W] & $past(ev)) == $past(ev))
    else $error("error log words not updated");

  mask_off_a: assert property (CE && ev == 10'h000 |=> !LOG_STORE)
    else $error("masked event was logged");

endmodule
`default_nettype wire

// File: sim/trl_programmer.sv
// Calibration programmer model that decodes the current frames on the alarm pin.
`timescale 1ns/100ps
`default_nettype none
module trl_programmer (
  input wire logic CORE_CLK,
  input wire logic ALARM_PIN,
  input var int HALF
);
  logic [7:0] bytes [$];
  int bad = 0;
  logic [17:0] lv;
  ////////////////////////////////////////////////////////////////////////////////
  // Each half is sampled in its middle, so the one-cycle launch offset does no harm.
  initial forever begin
    @(posedge CORE_CLK iff ALARM_PIN === 1'b0);
    repeat (HALF / 2) @(posedge CORE_CLK);
    for (int i = 0; i < 18; i++) begin
      lv[i] = ALARM_PIN === 1'b0;
      repeat (HALF) @(posedge CORE_CLK);
    end
    if (lv[0] !== 1'b1 || lv[1] !== 1'b0) bad++;
    for (int k = 1; k < 9; k++) if (lv[2*k] === lv[2*k+1]) bad++;
    bytes.push_back({lv[2], lv[4], lv[6], lv[8], lv[10], lv[12], lv[14], lv[16]});
  end
endmodule
`default_nettype wire

// File: sim/test_readout_and_error_log_tb.sv
// Self-checking bench for the readout and error log block.
`timescale 1ns/100ps
`default_nettype none
`include "trl_defines.svh"
module test_readout_and_error_log_tb;
  logic CORE_CLK = 1'b0, ARST_N = 1'b0, CE = 1'b1, TEST_ENTRY = 1'b0, TEST_EXIT = 1'b1;
  logic FULL_RELOAD = 1'b1, EE_ACK = 1'b0, EE_NACK = 1'b0, TGT_WR = 1'b0, ee_mute = 1'b0;
  logic [9:0] ERR_EVENT = 10'h000;
  logic [7:0] EE_DATA = 8'h00, TGT_DATA = 8'h00;
  logic [6:0] TGT_DEV = 7'h00, TGT_ADDR = 7'h00;
  logic [6:0] EE_ADDR, ee_last;
  logic EE_REQ, ERR_SINK_O, ERR_SINK_OE, TEST_MODE, RUN_ENABLE, TARGET_ENABLE, LOG_STORE, alarm_pin;
  logic [7:0] ee_mem [128];
  logic [10:0] rows [11] = '{11'h401, 11'h402, 11'h404, 11'h408, 11'h410, 11'h420, 11'h040, 11'h080,
    11'h100, 11'h600, 11'h000};
  int num_errors = 0, checked = 0, cycles = 0, ee_wait = 0, ee_count = 0, half = `HALF_FAST, n;
  // The pin has a pull-up, so it is high whenever the sink is off.
  assign alarm_pin = ERR_SINK_OE ? ERR_SINK_O : 1'b1;
  always #2 CORE_CLK = ~CORE_CLK;
  trl_readout #(.EE_TIMEOUT(50)) dut (.CORE_CLK, .ARST_N, .CE, .TEST_ENTRY, .TEST_EXIT, .FULL_RELOAD,
    .ERR_EVENT, .EE_REQ, .EE_ADDR, .EE_ACK, .EE_NACK, .EE_DATA, .TGT_WR, .TGT_DEV, .TGT_ADDR, .TGT_DATA,
    .ERR_SINK_O, .ERR_SINK_OE, .TEST_MODE, .RUN_ENABLE, .TARGET_ENABLE, .LOG_STORE);
  trl_programmer prog (.CORE_CLK, .ALARM_PIN(alarm_pin), .HALF(half));
  ////////////////////////////////////////////////////////////////////////////////
  // The EEPROM answers two cycles after a request and scrambles its data once released.
  always @(negedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      report_and_stop();
    end
    if (EE_ACK) EE_DATA <= ~EE_DATA;
    EE_ACK <= 1'b0;
    if (EE_REQ === 1'b1 && !EE_ACK && !ee_mute) begin
      ee_wait <= ee_wait + 1;
      if (ee_wait == 1) begin
        EE_ACK <= 1'b1;
        EE_DATA <= ee_mem[EE_ADDR];
        ee_last <= EE_ADDR;
        ee_count <= ee_count + 1;
        ee_wait <= 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_lvl(input string name, ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(negedge CORE_CLK);
      n++;
    end
    chk(name, sig, lvl);
  endtask
  // Leaves the strobe high so that back-to-back writes never toggle it within one step.
  task automatic tgt(input logic [6:0] dev, input logic [6:0] addr, input logic [7:0] data);
    TGT_WR = 1'b1;
    TGT_DEV = dev;
    TGT_ADDR = addr;
    TGT_DATA = data;
    @(negedge CORE_CLK);
  endtask
  task automatic low_run(input string name, input int exp);
    int len;
    len = 0;
    while (alarm_pin !== 1'b0 && len < 2000) begin
      @(negedge CORE_CLK);
      len++;
    end
    len = 0;
    while (alarm_pin === 1'b0 && len < 2000) begin
      @(negedge CORE_CLK);
      len++;
    end
    chk(name, len, exp);
  endtask
  task automatic enter(input logic on);
    TEST_ENTRY = on;
    TEST_EXIT = ~on;
    wait_lvl("TEST_MODE", TEST_MODE, on, 10);
  endtask
  task automatic reload(input int exp);
    ee_count = 0;
    wait_lvl("EE_REQ", EE_REQ, 1'b1, 4);
    wait_lvl("EE_REQ", EE_REQ, 1'b0, 500);
    chk("ee_count", ee_count, exp);
  endtask
  task automatic report_and_stop();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 128; i++) ee_mem[i] = 8'(i) ^ 8'hA5;
    ee_mem[7'h1B] = 8'h3F;
    ee_mem[7'h1C] = 8'h52;
    ee_mem[7'h1D] = 8'h07;
    repeat (4) @(negedge CORE_CLK);
    chk("EE_REQ", EE_REQ, 0);
    chk("ERR_SINK_OE", ERR_SINK_OE, 0);
    chk("TEST_MODE", TEST_MODE, 0);
    ARST_N = 1'b1;
    reload(128);
    chk("ee_last", ee_last, 7'h7F);
    chk("TARGET_ENABLE", TARGET_ENABLE, 1);
    foreach (rows[i]) begin
      ERR_EVENT = rows[i][9:0];
      @(negedge CORE_CLK);
      chk("LOG_STORE", LOG_STORE, rows[i][10]);
    end
    ERR_EVENT = 10'h000;
    tgt(`TGT_DEV, `CTRL_ADDR, 8'h06);
    chk("RUN_ENABLE", RUN_ENABLE, 0);
    // The log words are cleared only while the converter stands still.
    for (int i = 0; i < 4; i++) tgt(`TGT_DEV, `LOG0 + 7'(i), 8'h00);
    tgt(7'h50, `CTRL_ADDR, 8'h07);
    chk("RUN_ENABLE", RUN_ENABLE, 0);
    tgt(`TGT_DEV, 7'h3B, 8'h8A);
    tgt(`TGT_DEV, 7'h3C, 8'h00);
    tgt(`TGT_DEV, `CTRL_ADDR, 8'h07);
    TGT_WR = 1'b0;
    chk("RUN_ENABLE", RUN_ENABLE, 1);
    enter(1'b1);
    low_run("half_fast", `HALF_FAST);
    n = 0;
    while (prog.bytes.size() < 9 && n < 40000) begin
      @(negedge CORE_CLK);
      n++;
    end
    chk("frames", prog.bytes.size(), 9);
    chk("byte0", prog.bytes[0], 8'h8A);
    chk("byte1", prog.bytes[1], 8'h00);
    for (int i = 2; i < 9; i++) chk("byte", prog.bytes[i], ee_mem[7'h3B + i]);
    chk("bad", prog.bad, 0);
    FULL_RELOAD = 1'b0;
    enter(1'b0);
    reload(50);
    tgt(`TGT_DEV, `SEL_ADDR, 8'h12);
    tgt(`TGT_DEV, `CTRL_ADDR, 8'h03);
    TGT_WR = 1'b0;
    half = `HALF_SLOW;
    enter(1'b1);
    wait_lvl("EE_REQ", EE_REQ, 1'b1, 10);
    chk("EE_ADDR", EE_ADDR, `OEM_EE_FIRST);
    low_run("half_slow", `HALF_SLOW);
    repeat (1100) @(negedge CORE_CLK);
    chk("sink_on", alarm_pin, 0);
    chk("ERR_SINK_O", ERR_SINK_O, 0);
    enter(1'b0);
    chk("ERR_SINK_OE", ERR_SINK_OE, 0);
    reload(50);
    tgt(`TGT_DEV, `SEL_ADDR, 8'h02);
    TGT_WR = 1'b0;
    // With select bit 0 clear the entry level must not start test mode at all.
    TEST_ENTRY = 1'b1;
    TEST_EXIT = 1'b0;
    n = 0;
    repeat (400) begin
      @(negedge CORE_CLK);
      n += int'(alarm_pin === 1'b0) + int'(EE_REQ === 1'b1);
    end
    chk("activity", n, 0);
    chk("TEST_MODE", TEST_MODE, 0);
    enter(1'b0);
    repeat (20) @(negedge CORE_CLK);
    chk("EE_REQ", EE_REQ, 0);
    ee_mute = 1'b1;
    ARST_N = 1'b0;
    @(negedge CORE_CLK);
    chk("TARGET_ENABLE", TARGET_ENABLE, 0);
    ARST_N = 1'b1;
    wait_lvl("TARGET_ENABLE", TARGET_ENABLE, 1'b1, 70);
    chk("late", n > 45, 1);
    chk("RUN_ENABLE", RUN_ENABLE, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
